// ### common/timer_pkg.sv
package timer_pkg;

    // clock and tick timing
    localparam int CLK_HZ          = 200_000_000;
    localparam int TICK_PERIOD_S   = 1;
    localparam int TICK_CYCLES     = TICK_PERIOD_S * CLK_HZ;
    localparam int FLASH_STEPS     = 8;
    localparam int LONG_PRESS_S    = 3;

    // interval limits, major:minor
    localparam int MINOR_PER_MAJOR = 60;
    localparam int MAX_MAJOR       = 99;
    localparam int MAX_MINOR       = 59;

    // register word addresses
    localparam logic [3:0] ADDR_CFG      = 4'h0;
    localparam logic [3:0] ADDR_PRI_IV   = 4'h1;
    localparam logic [3:0] ADDR_SEC_IV   = 4'h2;
    localparam logic [3:0] ADDR_SETPOINT = 4'h3;
    localparam logic [3:0] ADDR_OUTMAP   = 4'h4;
    localparam logic [3:0] ADDR_STATUS   = 4'h5;
    localparam logic [3:0] ADDR_COUNT    = 4'h6;

    // configuration word fields
    localparam int CFG_START_LO   = 0;
    localparam int CFG_END_ON     = 2;
    localparam int CFG_END_DISABLE = 3;
    localparam int CFG_DOWN       = 4;
    localparam int CFG_MINSEC     = 5;
    localparam int CFG_RUN        = 6;

    // reset values
    localparam logic [15:0] CFG_RST      = 16'h0000;
    localparam logic [15:0] IV_RST       = 16'h0000;
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    localparam logic [7:0]  OUTMAP_RST   = 8'hE4;

    typedef enum logic [1:0] {START_OFF = 2'h0, START_SP = 2'h1, START_KEY = 2'h2, START_RUN = 2'h3} start_src_t;
    typedef enum logic [1:0] {SRC_CTRL = 2'h0, SRC_ALARM = 2'h1, SRC_PRI = 2'h2, SRC_SEC = 2'h3} chan_src_t;
    typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_PRI = 4'h2, ST_SEC = 4'h4, ST_DONE = 4'h8} seq_state_t;

endpackage

// ### common/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
    logic tick;
    logic flashSlow;
    logic flashFast;
    modport gen (output tick, output flashSlow, output flashFast);
    modport use_ (input tick, input flashSlow, input flashFast);
endinterface

// ### verilog/sec_tick_gen.sv
`timescale 1ns/1ps
module sec_tick_gen
    import timer_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    tick_if.gen       tk
);
    localparam int STEP = TICKS / FLASH_STEPS;
    localparam int CW   = $clog2(STEP);

    generate
        if (TICKS < 2 * FLASH_STEPS || (TICKS % FLASH_STEPS) != 0) begin : g_bad
            $error("tick length must be a positive multiple of the flash steps");
        end
    endgenerate

    logic [CW-1:0] subCnt_r;
    logic [2:0]    stepCnt_r;
    wire           stepWrap = (subCnt_r == CW'(STEP - 1));

    // one counter chain gives both tick and flash phases, so lamps stay in step with counting
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            subCnt_r     <= '0;
            stepCnt_r    <= '0;
            tk.tick      <= 1'b0;
            tk.flashSlow <= 1'b0;
            tk.flashFast <= 1'b0;
        end else begin
            subCnt_r     <= stepWrap ? '0 : subCnt_r + 1'b1;
            stepCnt_r    <= stepWrap ? stepCnt_r + 1'b1 : stepCnt_r;
            tk.tick      <= stepWrap && (stepCnt_r == 3'h7);  // RL22
            tk.flashSlow <= stepCnt_r[2];
            tk.flashFast <= stepCnt_r[0];
        end
    end
endmodule // sec_tick_gen

// ### verilog/dual_sequential_process_timer.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// Summary of operation
// RL1: timers run apart from control action; neither affects the other
// RL2: a sequence always starts with primary timer; secondary starts when primary ends
// RL3: time base selects hours:minutes or minutes:seconds for both intervals
// RL4: primary interval accepted from 00:00 to 99:59
// RL5: start source off disables both timers
// RL6: setpoint mode starts when process value reaches setpoint
// RL7: key mode starts on a detected key press
// RL8: short key press alternately pauses and resumes running count
// RL9: key held three seconds ends the cycle at once
// RL10: key starts honoured only while control is enabled
// RL11: run mode starts when control enable turns on
// RL12: end-on: primary output off while counting, on from expiry until new cycle
// RL13: end-on: primary lamp flashes while counting, steady after expiry
// RL14: end-off: primary output on during counting; lamp flashes then goes dark
// RL15: paused timer lamp flashes faster
// RL16: end action may clear control enable after both intervals
// RL17: secondary output on exactly while secondary interval runs
// RL18: secondary lamp flashes while counting, off otherwise
// RL19: direction selects up from zero or down from interval
// RL20: each output channel may follow either timer output
// RL21: control disabled forces control and alarm outputs off
// RL22: one-second tick from clock paces timers; reset clears all state (the output map loads E4 instead)
module dual_sequential_process_timer
    import timer_pkg::*;
#(
    parameter int TICKS    = TICK_CYCLES,
    parameter int CHANNELS = 4
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic [3:0]            regAddr,
    input  wire logic [15:0]           regWrData,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    output logic      [15:0]           regRdData,
    input  wire logic                  keyPin,
    input  wire logic [15:0]           processValue,
    input  wire logic                  ctrlDemand,
    input  wire logic                  alarmDemand,
    output logic      [CHANNELS-1:0]   outChan,
    output logic                       primaryTimerLamp,
    output logic                       secondaryTimerLamp,
    output logic                       controlEnable
);
    generate
        if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad
            $error("output map holds one to four channels");
        end
    endgenerate

    tick_if tk ();

    sec_tick_gen #(.TICKS(TICKS)) u_tick (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tk      (tk)
    );

    function automatic logic [12:0] to_minor(input logic [15:0] iv);
        to_minor = 13'(iv[15:8]) * 13'(MINOR_PER_MAJOR) + 13'(iv[7:0]);
    endfunction

    function automatic logic [15:0] pack_mm(input logic [12:0] v);
        pack_mm = {8'(v / 13'(MINOR_PER_MAJOR)), 8'(v % 13'(MINOR_PER_MAJOR))};
    endfunction

    function automatic logic [15:0] clamp_iv(input logic [15:0] d);
        logic [7:0] maj;
        logic [7:0] mnr;
        maj = (d[15:8] > 8'(MAX_MAJOR)) ? 8'(MAX_MAJOR) : d[15:8];
        mnr = (d[7:0] > 8'(MAX_MINOR)) ? 8'(MAX_MINOR) : d[7:0];
        clamp_iv = {maj, mnr};
    endfunction

    function automatic logic chan_pick(input logic [1:0] sel, input logic c, input logic a,
                                       input logic p, input logic s);
        chan_pick = (sel == SRC_CTRL) ? c : (sel == SRC_ALARM) ? a : (sel == SRC_PRI) ? p : s;
    endfunction

    // registers
    logic [15:0]   cfg_r;
    logic [15:0]   priIv_r;
    logic [15:0]   secIv_r;
    logic [15:0]   setpoint_r;
    logic [7:0]    outMap_r;
    logic          runEn_r;
    logic          runEnPrev_r;
    logic [15:0]   rdData_r;

    // key path
    logic          keyS1_r;
    logic          keyS2_r;
    logic          keyS3_r;
    logic          keyLevel_r;
    logic [1:0]    holdSec_r;
    logic          longFired_r;

    // sequence
    seq_state_t    state_r;
    seq_state_t    state_nxt;
    logic [12:0]   elapsed_r;
    logic [12:0]   elapsed_nxt;
    logic [5:0]    secInMin_r;
    logic          paused_r;
    logic          paused_nxt;
    logic          spReached_r;

    // outputs
    logic [CHANNELS-1:0] outChan_r;
    logic          priLamp_r;
    logic          secLamp_r;
    logic          priOut_r;
    logic          secOut_r;

    start_src_t    startSel;
    assign startSel = start_src_t'(cfg_r[CFG_START_LO +: 2]);
    wire endOn      = cfg_r[CFG_END_ON];
    wire endDisable = cfg_r[CFG_END_DISABLE];
    wire countDown  = cfg_r[CFG_DOWN];
    wire minSecBase = cfg_r[CFG_MINSEC];

    // key: only the agreeing second and third stages decide the level
    wire keyLevelNxt = (keyS2_r == keyS3_r) ? keyS3_r : keyLevel_r;
    wire keyRelease  = keyLevel_r && !keyLevelNxt;
    wire keyLongHit  = keyLevel_r && tk.tick && !longFired_r && (holdSec_r == 2'(LONG_PRESS_S - 1));
    wire keyShort    = keyRelease && !longFired_r && runEn_r;                  // RL7 RL10
    wire keyLong     = keyLongHit && runEn_r;                                  // RL10

    wire inRun      = (state_r == ST_PRI) || (state_r == ST_SEC);
    wire inRest     = (state_r == ST_IDLE) || (state_r == ST_DONE);
    wire counting   = inRun && !paused_r;
    wire spReached  = $signed(processValue) >= $signed(setpoint_r);
    wire spRise     = spReached && !spReached_r;
    wire runRise    = runEn_r && !runEnPrev_r;

    wire [12:0] priIvMin = to_minor(priIv_r);
    wire [12:0] secIvMin = to_minor(secIv_r);
    wire [12:0] activeIv = (state_r == ST_SEC) ? secIvMin : priIvMin;
    wire        expired  = inRun && (elapsed_r >= activeIv);

    // minutes base waits for a full minute of ticks before the minor unit moves
    wire minorStep = counting && tk.tick && (minSecBase || secInMin_r == 6'(MINOR_PER_MAJOR - 1));  // RL3 RL22

    wire startEvt = inRest && (((startSel == START_SP) && spRise)                 // RL6
                            || ((startSel == START_KEY) && keyShort)              // RL7
                            || ((startSel == START_RUN) && runRise));             // RL11
    wire pauseTgl  = inRun && (startSel == START_KEY) && keyShort;                // RL8
    wire terminate = inRun && (startSel == START_KEY) && keyLong;                 // RL9
    wire seqEnd    = (state_r == ST_SEC) && expired && !terminate;

    always_comb begin
        state_nxt = state_r;
        if (startSel == START_OFF) begin
            state_nxt = ST_IDLE;  // RL5
        end else begin
            case (state_r)
                ST_IDLE, ST_DONE: begin
                    if (startEvt) begin
                        state_nxt = ST_PRI;  // RL2
                    end
                end
                ST_PRI: begin
                    if (terminate) begin
                        state_nxt = ST_IDLE;
                    end else if (expired) begin
                        state_nxt = ST_SEC;  // RL2
                    end
                end
                ST_SEC: begin
                    if (terminate) begin
                        state_nxt = ST_IDLE;
                    end else if (expired) begin
                        state_nxt = ST_DONE;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    wire stateChange = (state_nxt != state_r);

    always_comb begin
        elapsed_nxt = elapsed_r;
        paused_nxt  = paused_r;
        if (stateChange) begin
            elapsed_nxt = '0;
            paused_nxt  = 1'b0;
        end else begin
            if (minorStep) begin
                elapsed_nxt = elapsed_r + 13'h0001;  // RL22
            end
            if (pauseTgl) begin
                paused_nxt = !paused_r;  // RL8
            end
        end
    end

    // outputs depend only on timer state, end mode and flash phase, never on control demand
    wire priOutNxt = endOn ? ((state_r == ST_SEC) || (state_r == ST_DONE))  // RL12 RL1
                           : (state_r == ST_PRI);                           // RL14
    wire secOutNxt = (state_r == ST_SEC);                                   // RL17
    wire flashNow  = paused_r ? tk.flashFast : tk.flashSlow;                // RL15
    wire priLampNxt = (state_r == ST_PRI) ? flashNow                        // RL13 RL14
                    : (endOn && ((state_r == ST_SEC) || (state_r == ST_DONE)));
    wire secLampNxt = (state_r == ST_SEC) && flashNow;                      // RL18

    wire ctrlGated  = ctrlDemand && runEn_r;   // RL21
    wire alarmGated = alarmDemand && runEn_r;  // RL21

    logic [CHANNELS-1:0] chanNxt;
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            assign chanNxt[gi] = chan_pick(outMap_r[2*gi +: 2], ctrlGated, alarmGated, priOut_r, secOut_r);  // RL20
        end
    endgenerate

    // displayed count; clipped at zero if the interval shrinks mid-count
    wire [12:0] remain   = (activeIv > elapsed_r) ? (activeIv - elapsed_r) : 13'h0000;
    wire [12:0] dispVal  = countDown ? remain : elapsed_r;  // RL19
    wire [15:0] statusWd = {10'h000, paused_r, runEn_r, state_r};

    wire [15:0] rdSel;
    assign rdSel = (regAddr == ADDR_CFG)      ? {cfg_r[15:CFG_RUN + 1], runEn_r, cfg_r[CFG_RUN - 1:0]}
                 : (regAddr == ADDR_PRI_IV)   ? priIv_r
                 : (regAddr == ADDR_SEC_IV)   ? secIv_r
                 : (regAddr == ADDR_SETPOINT) ? setpoint_r
                 : (regAddr == ADDR_OUTMAP)   ? {8'h00, outMap_r}
                 : (regAddr == ADDR_STATUS)   ? statusWd
                 : (regAddr == ADDR_COUNT)    ? pack_mm(dispVal)
                 : 16'h0000;

    wire wrCfg = regWrEn && (regAddr == ADDR_CFG);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_r      <= CFG_RST;
            priIv_r    <= IV_RST;
            secIv_r    <= IV_RST;
            setpoint_r <= SETPOINT_RST;
            outMap_r   <= OUTMAP_RST;
            rdData_r   <= 16'h0000;
        end else begin
            if (wrCfg) begin
                cfg_r <= regWrData;
            end
            if (regWrEn && regAddr == ADDR_PRI_IV) begin
                priIv_r <= clamp_iv(regWrData);  // RL4
            end
            if (regWrEn && regAddr == ADDR_SEC_IV) begin
                secIv_r <= clamp_iv(regWrData);
            end
            if (regWrEn && regAddr == ADDR_SETPOINT) begin
                setpoint_r <= regWrData;
            end
            if (regWrEn && regAddr == ADDR_OUTMAP) begin
                outMap_r <= regWrData[7:0];
            end
            rdData_r <= regRdEn ? rdSel : 16'h0000;
        end
    end

    // end-of-sequence clear beats a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            runEn_r     <= 1'b0;
            runEnPrev_r <= 1'b0;
        end else begin
            if (seqEnd && endDisable) begin
                runEn_r <= 1'b0;  // RL16
            end else if (wrCfg) begin
                runEn_r <= regWrData[CFG_RUN];
            end
            runEnPrev_r <= runEn_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            keyS1_r     <= 1'b0;
            keyS2_r     <= 1'b0;
            keyS3_r     <= 1'b0;
            keyLevel_r  <= 1'b0;
            holdSec_r   <= '0;
            longFired_r <= 1'b0;
        end else begin
            keyS1_r    <= keyPin;
            keyS2_r    <= keyS1_r;
            keyS3_r    <= keyS2_r;
            keyLevel_r <= keyLevelNxt;
            if (!keyLevel_r) begin
                holdSec_r   <= '0;
                longFired_r <= 1'b0;
            end else if (tk.tick && !longFired_r) begin
                holdSec_r   <= holdSec_r + 1'b1;
                longFired_r <= keyLongHit;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r     <= ST_IDLE;  // RL22
            elapsed_r   <= '0;
            secInMin_r  <= '0;
            paused_r    <= 1'b0;
            spReached_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            elapsed_r   <= elapsed_nxt;
            paused_r    <= paused_nxt;
            spReached_r <= spReached;
            if (stateChange || minorStep) begin
                secInMin_r <= '0;
            end else if (counting && tk.tick) begin
                secInMin_r <= secInMin_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            outChan_r <= '0;
            priLamp_r <= 1'b0;
            secLamp_r <= 1'b0;
            priOut_r  <= 1'b0;
            secOut_r  <= 1'b0;
        end else begin
            outChan_r <= chanNxt;
            priLamp_r <= priLampNxt;
            secLamp_r <= secLampNxt;
            priOut_r  <= priOutNxt;
            secOut_r  <= secOutNxt;
        end
    end

    assign regRdData          = rdData_r;
    assign outChan            = outChan_r;
    assign primaryTimerLamp   = priLamp_r;
    assign secondaryTimerLamp = secLamp_r;
    assign controlEnable      = runEn_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_off_idle: assert property (startSel == START_OFF |=> state_r == ST_IDLE)  // RL5
        else $error("timer not idle with start source off");
    chk_sec_after_pri: assert property ($rose(state_r == ST_SEC) |-> $past(state_r) == ST_PRI)  // RL2
        else $error("secondary entered without primary");
    chk_sec_output: assert property (state_r == ST_SEC ##1 state_r == ST_SEC |=> secOut_r)  // RL17
        else $error("secondary output off while secondary counts");
    chk_ctrl_forced: assert property ((!runEn_r && outMap_r[1:0] == SRC_CTRL) |=> !outChan[0])  // RL21
        else $error("control channel driven while disabled");
    chk_key_ignored: assert property ((startSel == START_KEY && !runEn_r && state_r == ST_IDLE)
                                      |=> state_r == ST_IDLE)  // RL10
        else $error("key start taken with control disabled");
    chk_pause_hold: assert property ((paused_r && state_r == ST_PRI) ##1 state_r == ST_PRI |-> $stable(elapsed_r))  // RL8
        else $error("count advanced while paused");
    chk_end_on_out: assert property ((endOn && state_r == ST_PRI) ##1 endOn |-> !priOut_r)  // RL12
        else $error("primary output on during counting in end-on mode");
    chk_fast_flash: assert property ((paused_r && state_r == ST_PRI) |=> priLamp_r == $past(tk.flashFast))  // RL15
        else $error("paused lamp not on fast flash");
    chk_run_start: assert property ((startSel == START_RUN && runRise && state_r == ST_IDLE)
                                    |=> state_r == ST_PRI)  // RL11
        else $error("run start not taken");
    chk_tick_pace: assert property (($changed(elapsed_r) && state_r == $past(state_r)) |-> $past(tk.tick))  // RL22
        else $error("count moved without a tick");
endmodule // dual_sequential_process_timer

// ### test/front_panel_model.sv
`timescale 1ns/1ps
module front_panel_model (
    input  wire logic        clk_sys,
    output logic             keyPin,
    output logic [15:0]      processValue,
    output logic             ctrlDemand,
    output logic             alarmDemand
);
    initial begin
        keyPin = 1'b0;
        processValue = 16'h0000;
        ctrlDemand = 1'b0;
        alarmDemand = 1'b0;
    end

    // key held for a count of system cycles; a short press acts on release, a long one while still held
    task automatic press(input int holdCycles);
        @(posedge clk_sys) keyPin <= 1'b1;
        repeat (holdCycles) @(posedge clk_sys);
        keyPin <= 1'b0;
    endtask

    // one-step change, as a fresh sensor sample would give
    task automatic setProcess(input logic [15:0] value);
        @(posedge clk_sys) processValue <= value;
    endtask

    task automatic setDemand(input logic ctrl, input logic alarm);
        @(posedge clk_sys) begin
            ctrlDemand <= ctrl;
            alarmDemand <= alarm;
        end
    endtask
endmodule // front_panel_model

// ### test/tb_dual_sequential_process_timer.sv
`timescale 1ns/1ps
module tb_dual_sequential_process_timer;
    import timer_pkg::*;
    // short tick keeps the run small; multiple of 8 for the flash divider
    localparam int TICKS = 64;
    logic        clk_sys;
    logic        rst_b;
    logic [3:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [15:0] regRdData;
    logic        keyPin;
    logic [15:0] processValue;
    logic        ctrlDemand;
    logic        alarmDemand;
    logic [3:0]  outChan;
    logic        primaryTimerLamp;
    logic        secondaryTimerLamp;
    logic        controlEnable;
    int          badCount;
    int          comparisons;
    int          np;
    int          ns;
    logic [15:0] d;

    dual_sequential_process_timer #(.TICKS(TICKS)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .keyPin(keyPin),
        .processValue(processValue), .ctrlDemand(ctrlDemand), .alarmDemand(alarmDemand),
        .outChan(outChan), .primaryTimerLamp(primaryTimerLamp),
        .secondaryTimerLamp(secondaryTimerLamp), .controlEnable(controlEnable)
    );

    front_panel_model i_panel (
        .clk_sys(clk_sys), .keyPin(keyPin), .processValue(processValue),
        .ctrlDemand(ctrlDemand), .alarmDemand(alarmDemand)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            badCount++;
        end
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys) begin
            regWrEn <= 1'b1;
            regAddr <= a;
            regWrData <= v;
        end
        @(posedge clk_sys) regWrEn <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic regRead(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys) begin
            regRdEn <= 1'b1;
            regAddr <= a;
        end
        @(posedge clk_sys) regRdEn <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic readCheck(input logic [3:0] a, input logic [15:0] exp, input string name);
        logic [15:0] v;
        regRead(a, v);
        check(name, exp, v);
    endtask

    task automatic waitState(input logic [3:0] st, input int bound);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < bound && s[3:0] !== st; i++) regRead(ADDR_STATUS, s);
        check("sequence state", {12'h000, st}, {12'h000, s[3:0]});
        if (s[3:0] !== st) print_verdict();
        else repeat (2) @(posedge clk_sys);
    endtask

    // lamp edges over two tick periods: slow flash gives about 4, fast about 16
    task automatic toggles(output int p, output int s);
        logic [1:0] prev;
        p = 0;
        s = 0;
        prev = {secondaryTimerLamp, primaryTimerLamp};
        repeat (128) begin
            @(posedge clk_sys);
            #1;
            if (primaryTimerLamp !== prev[0]) p++;
            if (secondaryTimerLamp !== prev[1]) s++;
            prev = {secondaryTimerLamp, primaryTimerLamp};
        end
    endtask

    initial begin
        badCount = 0;
        comparisons = 0;
        rst_b = 1'b0;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        readCheck(ADDR_CFG, 16'h0000, "cfg reset");
        readCheck(ADDR_OUTMAP, 16'h00E4, "outmap reset");
        readCheck(ADDR_STATUS, 16'h0001, "status reset");
        readCheck(4'hF, 16'h0000, "unmapped read");
        regWrite(ADDR_PRI_IV, 16'h6A4F);
        readCheck(ADDR_PRI_IV, 16'h633B, "interval clamp");
        $display("test reset_regs done");

        i_panel.setDemand(1'b1, 1'b1);
        regWrite(ADDR_CFG, 16'h0040);
        i_panel.press(20);
        repeat (20) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0011, "off mode idle");
        check("outputs enabled", 16'h0003, {14'h0, outChan[1:0]});
        regWrite(ADDR_CFG, 16'h002F);
        repeat (3) @(posedge clk_sys);
        check("outputs disabled", 16'h0000, {14'h0, outChan[1:0]});
        $display("test off_mode done");

        regWrite(ADDR_PRI_IV, 16'h0005);
        regWrite(ADDR_SEC_IV, 16'h0004);
        regWrite(ADDR_CFG, 16'h006F);
        waitState(ST_PRI, 4);
        regRead(ADDR_COUNT, d);
        check("up count start", 16'h0001, {15'h0, d < 16'h0002});
        check("primary outputs", 16'h0003, {12'h0, outChan});
        i_panel.setDemand(1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        check("alarm only", 16'h0002, {12'h0, outChan});
        i_panel.setDemand(1'b1, 1'b0);
        repeat (2) @(posedge clk_sys);
        check("control only", 16'h0001, {12'h0, outChan});
        i_panel.setDemand(1'b1, 1'b1);
        readCheck(ADDR_STATUS, 16'h0012, "timing ignores demand");
        toggles(np, ns);
        check("primary lamp slow", 16'h0001, {15'h0, np inside {[3:5]}});
        waitState(ST_SEC, 400);
        check("secondary outputs", 16'h000F, {12'h0, outChan});
        toggles(np, ns);
        check("secondary lamp flash", 16'h0001, {15'h0, ns inside {[3:5]}});
        check("primary lamp steady", 16'h0001, {15'h0, np == 0 && primaryTimerLamp === 1'b1});
        waitState(ST_DONE, 400);
        check("done outputs", 16'h0004, {12'h0, outChan});
        check("end clears enable", 16'h0000, {15'h0, controlEnable});
        check("secondary lamp off", 16'h0000, {15'h0, secondaryTimerLamp});
        $display("test run_mode done");

        regWrite(ADDR_OUTMAP, 16'h00E7);
        regWrite(ADDR_SETPOINT, 16'h0064);
        regWrite(ADDR_PRI_IV, 16'h0001);
        regWrite(ADDR_SEC_IV, 16'h0001);
        i_panel.setProcess(16'h0032);
        regWrite(ADDR_CFG, 16'h0040);
        regWrite(ADDR_CFG, 16'h0041);
        repeat (20) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0011, "below setpoint idle");
        i_panel.setProcess(16'h0078);
        waitState(ST_PRI, 4);
        check("setpoint primary outputs", 16'h0006, {12'h0, outChan});
        toggles(np, ns);
        check("end-off lamp flash", 16'h0001, {15'h0, np inside {[3:5]}});
        repeat (1920) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0012, "minute base running");
        waitState(ST_SEC, 1200);
        check("setpoint secondary outputs", 16'h000B, {12'h0, outChan});
        toggles(np, ns);
        check("end-off lamp dark", 16'h0001, {15'h0, np == 0 && primaryTimerLamp === 1'b0});
        regWrite(ADDR_CFG, 16'h0040);
        repeat (3) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0011, "off forces idle");
        $display("test setpoint_mode done");

        regWrite(ADDR_PRI_IV, 16'h0A00);
        regWrite(ADDR_CFG, 16'h0032);
        i_panel.press(20);
        repeat (10) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0001, "key ignored disabled");
        regWrite(ADDR_CFG, 16'h0072);
        i_panel.press(20);
        waitState(ST_PRI, 8);
        regRead(ADDR_COUNT, d);
        check("down count start", 16'h0001, {15'h0, d[15:8] >= 8'h09});
        i_panel.press(20);
        repeat (10) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0032, "short press pauses");
        toggles(np, ns);
        check("paused lamp fast", 16'h0001, {15'h0, np > 10});
        i_panel.press(20);
        repeat (10) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0012, "short press resumes");
        i_panel.press(260);
        repeat (10) @(posedge clk_sys);
        readCheck(ADDR_STATUS, 16'h0011, "long press ends");
        regWrite(ADDR_PRI_IV, 16'h0000);
        regWrite(ADDR_SEC_IV, 16'h0000);
        i_panel.press(20);
        waitState(ST_DONE, 8);
        check("end keeps control", 16'h0001, {15'h0, controlEnable});
        $display("test key_mode done");
        print_verdict();
    end
endmodule // tb_dual_sequential_process_timer
